// File: hdl/adccfg_pkg.sv
package adccfg_pkg;

  // Register indices; byte address is four times the index.
  localparam logic [3:0] IDX_CONTROL   = 4'h0;
  localparam logic [3:0] IDX_CH1_PRI   = 4'h2;
  localparam logic [3:0] IDX_CH1_SEC   = 4'h3;
  localparam logic [3:0] IDX_CH2_PRI   = 4'h5;
  localparam logic [3:0] IDX_CH2_SEC   = 4'h6;
  localparam logic [3:0] IDX_TEMP_PRI  = 4'h8;
  localparam logic [3:0] IDX_TEMP_SEC  = 4'h9;
  localparam logic [3:0] IDX_CONV_STAT = 4'hA;

  // Writable bit masks per register.
  localparam logic [15:0] MASK_CH_PRI   = 16'hFF7F;
  localparam logic [15:0] MASK_TEMP_PRI = 16'h077F;
  localparam logic [15:0] MASK_CH_SEC   = 16'h0073;
  localparam logic [15:0] MASK_TEMP_SEC = 16'h0070;
  localparam logic [15:0] MASK_CONTROL  = 16'h0F07;

  // Values after reset.
  localparam logic [15:0] RST_PRI     = 16'h0000;
  localparam logic [15:0] RST_SEC     = 16'h0070;
  localparam logic [15:0] RST_CONTROL = 16'h0000;

  // Field positions.
  localparam int GAIN_LSB = 11;
  localparam int CLK_LSB  = 8;
  localparam int RES_LSB  = 4;
  localparam int BIAS_LSB = 4;
  localparam int SRC_LSB  = 8;

  // Single-ended source codes.
  localparam logic [3:0] SRC_NONE     = 4'h0;
  localparam logic [3:0] SRC_BANDGAP  = 4'h1;
  localparam logic [3:0] SRC_SMALL    = 4'h2;
  localparam logic [3:0] SRC_LARGE    = 4'h3;
  localparam logic [3:0] SRC_SUPPLY   = 4'h4;
  localparam logic [3:0] SRC_GROUND   = 4'h5;
  localparam logic [3:0] SRC_DAC_SM   = 4'h6;
  localparam logic [3:0] SRC_DAC_LG   = 4'h7;
  localparam logic [3:0] SRC_POS_PIN  = 4'h8;
  localparam logic [3:0] SRC_NEG_PIN  = 4'h9;

  // Route codes on the positive ADC input.
  typedef enum logic [3:0] {
    ADCCFG_RT_DIFF    = 4'h0,
    ADCCFG_RT_BANDGAP = 4'h1,
    ADCCFG_RT_SMALL   = 4'h2,
    ADCCFG_RT_LARGE   = 4'h3,
    ADCCFG_RT_SUPPLY  = 4'h4,
    ADCCFG_RT_GROUND  = 4'h5,
    ADCCFG_RT_DAC_SM  = 4'h6,
    ADCCFG_RT_DAC_LG  = 4'h7,
    ADCCFG_RT_POS     = 4'h8,
    ADCCFG_RT_NEG     = 4'h9,
    ADCCFG_RT_NONE    = 4'hF
  } adccfg_route_e;

  // Gain selection code 31 means the fixed reduced gain, 30 undefined.
  localparam logic [4:0] GSEL_FIXED = 5'h1F;
  localparam logic [4:0] GSEL_UNDEF = 5'h1E;

  // Converter busy time per conversion, in cycles.
  localparam logic [7:0] CONV_CYCLES = 8'h10;

  typedef enum logic [1:0] {
    ADCCFG_IDLE = 2'b00,
    ADCCFG_BUSY = 2'b01,
    ADCCFG_DONE = 2'b11
  } adccfg_state_e;

endpackage : adccfg_pkg

// File: hdl/adccfg_regs.sv
// Overview of operation
// (RULE_01) Codes 0010/0011 route small/large amplifier output.
// (RULE_02) Codes 0110/0111 convert DAC via follower.
// (RULE_03) Codes 1000/1001 convert positive/negative pin.
// (RULE_04) Supply, ground, DAC codes force 0.7 gain.
// (RULE_05) Channel 1 primary: gain, divider, resolution.
// (RULE_06) Bit 3 offset sign, bits 2-0 magnitude.
// (RULE_07) Channel 1 secondary: bias and reference.
// (RULE_08) Channel 2 primary mirrors channel 1.
// (RULE_09) Channel 2 secondary: bias and reference.
// (RULE_10) Temperature primary has no gain field.
// (RULE_11) Temperature secondary holds only bias.
// (RULE_12) Decode gain code into seventeen gains.
// (RULE_13) Start bit converts with own settings, self-clears; if several are set, only the top-priority one converts and all clear.
// (RULE_14) Source codes apply only to channels.
// (RULE_15) Unused bits read zero, ignore writes.
// (RULE_16) Software uses only listed codes.
module adccfg_regs (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             cpu_halt,
  output logic             conv_active,
  output logic [1:0]       conv_channel,
  output logic [3:0]       adc_route,
  output logic [4:0]       gain_select,
  output logic [2:0]       adc_clock_divider_code,
  output logic [2:0]       conversion_resolution_code,
  output logic             coarse_offset_sign,
  output logic [2:0]       coarse_offset_magnitude,
  output logic [2:0]       converter_bias_code,
  output logic [1:0]       reference_source_select
);

  logic [15:0] ch1_pri_reg;
  logic [15:0] ch1_sec_reg;
  logic [15:0] ch2_pri_reg;
  logic [15:0] ch2_sec_reg;
  logic [15:0] temp_pri_reg;
  logic [15:0] temp_sec_reg;
  logic [15:0] control_reg;
  logic [7:0]  conv_cnt_reg;
  logic [2:0]  done_reg;
  adccfg_pkg::adccfg_state_e state_reg;

  logic        wr_en;
  logic        rd_en;
  logic [3:0]  idx;
  logic        addr_ok;
  logic [15:0] wdata;
  logic [15:0] rd_word;
  logic [1:0]  sel_chan;
  logic [15:0] pri_sel;
  logic [15:0] sec_sel;
  logic [3:0]  src;
  adccfg_pkg::adccfg_route_e route_next;
  logic [4:0]  gsel_next;

  // Address decode: aligned words, index in bits 5..2.
  assign idx     = paddr[5:2];
  assign addr_ok = (paddr[7:6] == 2'b00) && (paddr[1:0] == 2'b00) &&
                   (idx == adccfg_pkg::IDX_CONTROL  ||
                    idx == adccfg_pkg::IDX_CH1_PRI  ||
                    idx == adccfg_pkg::IDX_CH1_SEC  ||
                    idx == adccfg_pkg::IDX_CH2_PRI  ||
                    idx == adccfg_pkg::IDX_CH2_SEC  ||
                    idx == adccfg_pkg::IDX_TEMP_PRI ||
                    idx == adccfg_pkg::IDX_TEMP_SEC ||
                    idx == adccfg_pkg::IDX_CONV_STAT);
  assign wr_en   = psel && penable && pwrite && addr_ok;
  assign rd_en   = psel && !pwrite;
  assign wdata   = pwdata[15:0];

  // Channel settings writes, unused bits masked off.
  // (RULE_05) channel 1 fields
  // (RULE_06) offset sign/magnitude kept
  // (RULE_08) channel 2 same fields
  // (RULE_15) unused bits dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch1_pri_reg <= adccfg_pkg::RST_PRI;
      ch2_pri_reg <= adccfg_pkg::RST_PRI;
    end else if (wr_en) begin
      if (idx == adccfg_pkg::IDX_CH1_PRI) begin
        ch1_pri_reg <= wdata & adccfg_pkg::MASK_CH_PRI;
      end
      if (idx == adccfg_pkg::IDX_CH2_PRI) begin
        ch2_pri_reg <= wdata & adccfg_pkg::MASK_CH_PRI;
      end
    end
  end

  // Secondary and temperature settings writes.
  // (RULE_07) bias and reference
  // (RULE_09) channel 2 bias/reference
  // (RULE_10) temperature no gain
  // (RULE_11) temperature bias only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch1_sec_reg  <= adccfg_pkg::RST_SEC;
      ch2_sec_reg  <= adccfg_pkg::RST_SEC;
      temp_pri_reg <= adccfg_pkg::RST_PRI;
      temp_sec_reg <= adccfg_pkg::RST_SEC;
    end else if (wr_en) begin
      if (idx == adccfg_pkg::IDX_CH1_SEC) begin
        ch1_sec_reg <= wdata & adccfg_pkg::MASK_CH_SEC;
      end
      if (idx == adccfg_pkg::IDX_CH2_SEC) begin
        ch2_sec_reg <= wdata & adccfg_pkg::MASK_CH_SEC;
      end
      if (idx == adccfg_pkg::IDX_TEMP_PRI) begin
        temp_pri_reg <= wdata & adccfg_pkg::MASK_TEMP_PRI;
      end
      if (idx == adccfg_pkg::IDX_TEMP_SEC) begin
        temp_sec_reg <= wdata & adccfg_pkg::MASK_TEMP_SEC;
      end
    end
  end

  // Control register; start bits self-clear when conversion ends.
  // (RULE_13) start and self-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_reg <= adccfg_pkg::RST_CONTROL;
    end else if (wr_en && idx == adccfg_pkg::IDX_CONTROL &&
                 state_reg == adccfg_pkg::ADCCFG_IDLE) begin
      control_reg <= wdata & adccfg_pkg::MASK_CONTROL;
    end else if (state_reg == adccfg_pkg::ADCCFG_DONE) begin
      control_reg[2:0] <= 3'h0;
    end
  end

  // Priority pick of channel: 1 over 2 over temperature.
  always_comb begin
    if (control_reg[2]) begin
      sel_chan = 2'd1;
      pri_sel  = ch1_pri_reg;
      sec_sel  = ch1_sec_reg;
    end else if (control_reg[1]) begin
      sel_chan = 2'd2;
      pri_sel  = ch2_pri_reg;
      sec_sel  = ch2_sec_reg;
    end else begin
      sel_chan = 2'd3;
      pri_sel  = temp_pri_reg;
      sec_sel  = temp_sec_reg;
    end
  end

  // Source decode into route and gain selection.
  assign src = control_reg[adccfg_pkg::SRC_LSB +: 4];
  always_comb begin
    route_next = adccfg_pkg::ADCCFG_RT_NONE;
    gsel_next  = adccfg_pkg::GSEL_UNDEF;
    // (RULE_12) gain code decode
    unique case (pri_sel[adccfg_pkg::GAIN_LSB +: 5])
      5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08,
      5'h0A, 5'h0C, 5'h0E, 5'h10, 5'h14, 5'h18, 5'h1C, 5'h1E: begin
        gsel_next = pri_sel[adccfg_pkg::GAIN_LSB +: 5];
      end
      default: begin
        gsel_next = adccfg_pkg::GSEL_UNDEF;
      end
    endcase
    if (sel_chan == 2'd3) begin
      // (RULE_14) temperature rejects any source
      route_next = (src == adccfg_pkg::SRC_NONE) ?
                   adccfg_pkg::ADCCFG_RT_DIFF : adccfg_pkg::ADCCFG_RT_NONE;
      gsel_next  = 5'h00;
    end else begin
      unique case (src)
        adccfg_pkg::SRC_NONE:    route_next = adccfg_pkg::ADCCFG_RT_DIFF;
        adccfg_pkg::SRC_BANDGAP: begin
          route_next = adccfg_pkg::ADCCFG_RT_BANDGAP;
          gsel_next  = 5'h00;
        end
        // (RULE_01) amplifier outputs
        adccfg_pkg::SRC_SMALL:   route_next = adccfg_pkg::ADCCFG_RT_SMALL;
        adccfg_pkg::SRC_LARGE:   route_next = adccfg_pkg::ADCCFG_RT_LARGE;
        // (RULE_04) fixed reduced gain
        adccfg_pkg::SRC_SUPPLY, adccfg_pkg::SRC_GROUND: begin
          route_next = adccfg_pkg::adccfg_route_e'(src);
          gsel_next  = adccfg_pkg::GSEL_FIXED;
        end
        // (RULE_02) DAC via follower
        adccfg_pkg::SRC_DAC_SM, adccfg_pkg::SRC_DAC_LG: begin
          route_next = adccfg_pkg::adccfg_route_e'(src);
          gsel_next  = adccfg_pkg::GSEL_FIXED;
        end
        // (RULE_03) sensor pins
        adccfg_pkg::SRC_POS_PIN: route_next = adccfg_pkg::ADCCFG_RT_POS;
        adccfg_pkg::SRC_NEG_PIN: route_next = adccfg_pkg::ADCCFG_RT_NEG;
        default:                 route_next = adccfg_pkg::ADCCFG_RT_NONE;
      endcase
    end
  end

  // Conversion sequencer holding the CPU while busy.
  // (RULE_13) halt during conversion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg    <= adccfg_pkg::ADCCFG_IDLE;
      conv_cnt_reg <= 8'h00;
    end else begin
      unique case (state_reg)
        adccfg_pkg::ADCCFG_IDLE: begin
          if (control_reg[2:0] != 3'h0) begin
            state_reg    <= adccfg_pkg::ADCCFG_BUSY;
            conv_cnt_reg <= adccfg_pkg::CONV_CYCLES;
          end
        end
        adccfg_pkg::ADCCFG_BUSY: begin
          conv_cnt_reg <= conv_cnt_reg - 8'h01;
          if (conv_cnt_reg == 8'h01) begin
            state_reg <= adccfg_pkg::ADCCFG_DONE;
          end
        end
        adccfg_pkg::ADCCFG_DONE: state_reg <= adccfg_pkg::ADCCFG_IDLE;
        default:                 state_reg <= adccfg_pkg::ADCCFG_IDLE;
      endcase
    end
  end

  // Sticky done flags; a finishing conversion wins over a clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_reg <= 3'h0;
    end else begin
      done_reg <= (wr_en && idx == adccfg_pkg::IDX_CONV_STAT) ?
                  (done_reg & ~pwdata[2:0]) : done_reg;
      if (state_reg == adccfg_pkg::ADCCFG_DONE) begin
        done_reg[3 - sel_chan] <= 1'b1;
      end
    end
  end

  // Settings presented to the analog front end, latched while busy.
  // (RULE_13) own channel settings used
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_active                <= 1'b0;
      cpu_halt                   <= 1'b0;
      conv_channel               <= 2'd0;
      adc_route                  <= adccfg_pkg::ADCCFG_RT_NONE;
      gain_select                <= 5'h00;
      adc_clock_divider_code     <= 3'h0;
      conversion_resolution_code <= 3'h0;
      coarse_offset_sign         <= 1'b0;
      coarse_offset_magnitude    <= 3'h0;
      converter_bias_code        <= 3'h0;
      reference_source_select    <= 2'h0;
    end else begin
      conv_active <= (state_reg == adccfg_pkg::ADCCFG_IDLE) ?
                     (control_reg[2:0] != 3'h0) :
                     (state_reg == adccfg_pkg::ADCCFG_BUSY &&
                      conv_cnt_reg != 8'h01);
      cpu_halt    <= (state_reg == adccfg_pkg::ADCCFG_IDLE) ?
                     (control_reg[2:0] != 3'h0) :
                     (state_reg == adccfg_pkg::ADCCFG_BUSY &&
                      conv_cnt_reg != 8'h01);
      if (state_reg == adccfg_pkg::ADCCFG_IDLE &&
          control_reg[2:0] != 3'h0) begin
        conv_channel               <= sel_chan;
        adc_route                  <= route_next;
        gain_select                <= gsel_next;
        adc_clock_divider_code     <= pri_sel[adccfg_pkg::CLK_LSB +: 3];
        conversion_resolution_code <= pri_sel[adccfg_pkg::RES_LSB +: 3];
        // (RULE_06) sign and magnitude
        coarse_offset_sign         <= pri_sel[3];
        coarse_offset_magnitude    <= pri_sel[2:0];
        converter_bias_code        <= sec_sel[adccfg_pkg::BIAS_LSB +: 3];
        reference_source_select    <= sec_sel[1:0];
      end
    end
  end

  // Read mux.
  always_comb begin
    unique case (idx)
      adccfg_pkg::IDX_CONTROL:   rd_word = control_reg;
      adccfg_pkg::IDX_CH1_PRI:   rd_word = ch1_pri_reg;
      adccfg_pkg::IDX_CH1_SEC:   rd_word = ch1_sec_reg;
      adccfg_pkg::IDX_CH2_PRI:   rd_word = ch2_pri_reg;
      adccfg_pkg::IDX_CH2_SEC:   rd_word = ch2_sec_reg;
      adccfg_pkg::IDX_TEMP_PRI:  rd_word = temp_pri_reg;
      adccfg_pkg::IDX_TEMP_SEC:  rd_word = temp_sec_reg;
      adccfg_pkg::IDX_CONV_STAT: rd_word = {13'h0000, done_reg};
      default:                   rd_word = 16'h0000;
    endcase
  end

  // APB answer: no wait states, error on unmapped addresses.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      prdata  <= (rd_en && !penable && addr_ok) ?
                 {16'h0000, rd_word} : 32'h0000_0000;
    end
  end

  // (RULE_15) unused bits read zero
  a_unused_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (ch1_pri_reg[7] == 1'b0) && (temp_pri_reg[15:11] == 5'h00))
    else $error("Unused bit set.");

  // (RULE_04) forced gain
  a_fixed_gain: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == adccfg_pkg::ADCCFG_IDLE && control_reg[2:1] != 2'b00 &&
     src inside {4'h4, 4'h5, 4'h6, 4'h7}) |=>
    gain_select == adccfg_pkg::GSEL_FIXED)
    else $error("Fixed gain not forced.");

  // (RULE_01) amplifier route
  a_amp_route: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == adccfg_pkg::ADCCFG_IDLE && control_reg[2:1] != 2'b00 &&
     src == 4'h3) |=> adc_route == adccfg_pkg::ADCCFG_RT_LARGE)
    else $error("Large amplifier not routed.");

  // (RULE_14) temperature source rejected
  a_temp_src: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == adccfg_pkg::ADCCFG_IDLE && control_reg[2:0] == 3'b001 &&
     src != 4'h0) |=> adc_route == adccfg_pkg::ADCCFG_RT_NONE)
    else $error("Temperature source not rejected.");

  sequence s_start;
    state_reg == adccfg_pkg::ADCCFG_IDLE && control_reg[2:0] != 3'h0;
  endsequence
  // (RULE_13) self clear after conversion
  a_self_clear: assert property (@(posedge pclk) disable iff (!presetn)
    s_start |=> cpu_halt ##17 (control_reg[2:0] == 3'h0 && !cpu_halt))
    else $error("Start bit did not clear.");

  // (RULE_12) gain decode
  a_gain_undef: assert property (@(posedge pclk) disable iff (!presetn)
    (s_start and (control_reg[2:1] != 2'b00) and (src == 4'h0) and
     (pri_sel[15:11] == 5'h09)) |=> gain_select == adccfg_pkg::GSEL_UNDEF)
    else $error("Unlisted gain decoded.");

  // (RULE_03) pin route
  a_pin_route: assert property (@(posedge pclk) disable iff (!presetn)
    (s_start and (control_reg[2:1] != 2'b00) and (src == 4'h8)) |=>
    adc_route == adccfg_pkg::ADCCFG_RT_POS)
    else $error("Positive pin not routed.");

  // (RULE_07) secondary mask
  a_sec_mask: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && idx == adccfg_pkg::IDX_CH1_SEC) |=>
    ch1_sec_reg == ($past(pwdata[15:0]) & 16'h0073))
    else $error("Secondary write wrong.");

endmodule : adccfg_regs

// File: tb/test_adccfg_regs.sv
module test_adccfg_regs;
  timeunit 1ns;
  timeprecision 1ns;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cpu_halt;
  logic        conv_active;
  logic [1:0]  conv_channel;
  logic [3:0]  adc_route;
  logic [4:0]  gain_select;
  logic [2:0]  adc_clock_divider_code;
  logic [2:0]  conversion_resolution_code;
  logic        coarse_offset_sign;
  logic [2:0]  coarse_offset_magnitude;
  logic [2:0]  converter_bias_code;
  logic [1:0]  reference_source_select;
  int          num_errors;
  int          samples_checked;
  int          seed;
  logic [15:0] model [0:15];
  logic [31:0] rd;
  logic        err;
  logic [4:0]  gains [0:16] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05,
    5'h06, 5'h07, 5'h08, 5'h0A, 5'h0C, 5'h0E, 5'h10, 5'h14, 5'h18, 5'h1C,
    5'h1E};

  adccfg_regs adccfg_regs_i (
    .pclk                       (pclk),
    .presetn                    (presetn),
    .psel                       (psel),
    .penable                    (penable),
    .pwrite                     (pwrite),
    .paddr                      (paddr),
    .pwdata                     (pwdata),
    .prdata                     (prdata),
    .pready                     (pready),
    .pslverr                    (pslverr),
    .cpu_halt                   (cpu_halt),
    .conv_active                (conv_active),
    .conv_channel               (conv_channel),
    .adc_route                  (adc_route),
    .gain_select                (gain_select),
    .adc_clock_divider_code     (adc_clock_divider_code),
    .conversion_resolution_code (conversion_resolution_code),
    .coarse_offset_sign         (coarse_offset_sign),
    .coarse_offset_magnitude    (coarse_offset_magnitude),
    .converter_bias_code        (converter_bias_code),
    .reference_source_select    (reference_source_select)
  );

  // The clock toggles every half period of 50 ns.
  initial pclk = 1'b0;
  always #50 pclk = ~pclk;

  task automatic close_out;
    if (num_errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val

  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Writable bits of each settings register; the rest read as zero.
  function automatic logic [15:0] mask_of(input logic [3:0] idx);
    case (idx)
      4'h2, 4'h5: mask_of = 16'hFF7F;
      4'h8:       mask_of = 16'h077F;
      4'h3, 4'h6: mask_of = 16'h0073;
      default:    mask_of = 16'h0070;
    endcase
  endfunction : mask_of

  task automatic check_reg(input logic [3:0] idx);
    apb(1'b0, {2'b00, idx, 2'b00}, 32'h0000_0000);
    check_val(rd, {16'h0000, model[idx]});
    check_val({31'h0000_0000, err}, 32'h0000_0000);
  endtask : check_reg

  // Random write with a listed gain code, then read back through the model.
  task automatic write_rand(input logic [3:0] idx);
    logic [31:0] w;
    w = $random(seed);
    w[15:11] = gains[$unsigned($random(seed)) % 17];
    apb(1'b1, {2'b00, idx, 2'b00}, w);
    model[idx] = w[15:0] & mask_of(idx);
    check_reg(idx);
  endtask : write_rand

  // Start one conversion and check the latched settings and route.
  task automatic run_conv(input int ch, input logic [3:0] src);
    logic [15:0] pri;
    logic [15:0] sec;
    int          n;
    pri = model[ch == 1 ? 2 : (ch == 2 ? 5 : 8)];
    sec = model[ch == 1 ? 3 : (ch == 2 ? 6 : 9)];
    apb(1'b1, 8'h00, {20'h0_0000, src, 5'h00, 3'(3'b1 << (3 - ch))});
    @(posedge pclk);
    #1;
    check_val({31'h0, cpu_halt}, 32'h1);
    check_val({31'h0, conv_active}, 32'h1);
    check_val({30'h0, conv_channel}, 32'(ch));
    check_val({29'h0, adc_clock_divider_code}, 32'(pri[10:8]));
    check_val({29'h0, conversion_resolution_code}, 32'(pri[6:4]));
    check_val({28'h0, coarse_offset_sign, coarse_offset_magnitude},
              32'(pri[3:0]));
    check_val({29'h0, converter_bias_code}, 32'(sec[6:4]));
    if (ch != 3) check_val({30'h0, reference_source_select},
                           32'(sec[1:0]));
    if (ch == 3) check_val({28'h0, adc_route},
                           (src != 4'h0) ? 32'hF : 32'h0);
    if (ch != 3) check_val({28'h0, adc_route}, 32'(src));
    if (ch != 3 && src != 4'h1) check_val({27'h0, gain_select},
      (src >= 4 && src <= 7) ? 32'h1F : ((pri[15:11] inside {gains}) ?
      32'(pri[15:11]) : 32'h1E));
    n = 0;
    while (cpu_halt !== 1'b0 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 200) num_errors++;
    repeat (4) @(posedge pclk);
    apb(1'b0, 8'h00, 32'h0000_0000);
    check_val(rd, {20'h0_0000, src, 8'h00});
    // Done flag of this channel is set, then cleared by writing ones.
    apb(1'b0, 8'h28, 32'h0000_0000);
    check_val(rd, 32'(3'b1 << (3 - ch)));
    apb(1'b1, 8'h28, 32'h0000_0007);
  endtask : run_conv

  // Watchdog cuts a hung run short.
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    close_out();
  end

  // Main sequence: reset, register checks, unmapped access, conversions.
  initial begin
    seed = 90279;
    num_errors = 0;
    samples_checked = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    for (int i = 0; i < 16; i++) model[i] = 16'h0000;
    model[3] = 16'h0070;
    model[6] = 16'h0070;
    model[9] = 16'h0070;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 2; i < 10; i++) begin
      if (i != 4 && i != 7) check_reg(4'(i));
    end
    for (int r = 0; r < 4; r++) begin
      for (int i = 2; i < 10; i++) begin
        if (i != 4 && i != 7) write_rand(4'(i));
      end
    end
    apb(1'b1, 8'h3C, 32'hFFFF_FFFF);
    check_val({31'h0, err}, 32'h1);
    apb(1'b0, 8'h3C, 32'h0000_0000);
    check_val({31'h0, err}, 32'h1);
    for (int s = 0; s < 10; s++) begin
      for (int c = 1; c < 3; c++) begin
        write_rand(c == 1 ? 4'h2 : 4'h5);
        write_rand(c == 1 ? 4'h3 : 4'h6);
        run_conv(c, 4'(s));
      end
    end
    // An unlisted gain code decodes as undefined.
    apb(1'b1, 8'h08, 32'h0000_4800);
    model[2] = 16'h4800;
    run_conv(1, 4'h0);
    write_rand(4'h8);
    run_conv(3, 4'h0);
    run_conv(3, 4'h5);
    close_out();
  end

endmodule : test_adccfg_regs
